/* File: logic/cta_pkg.sv */
// Purpose: shared constants and carrier types for the converter test and agc limit bank
// Assumes: apb data 32 bits, each register one aligned word at byte address index*4
// Notes: register indices are kept as printed; only the low 8 bits of each word are stored
package cta_pkg;
  // register indices, byte address is index times four
  localparam logic [7:0] IDX_CLK_GATING = 8'h18; // converter_clock_gating
  localparam logic [7:0] IDX_PWR_OVERRIDE = 8'h1A; // converter_power_override
  localparam logic [7:0] IDX_FMT_OBSERVE = 8'h1C; // converter_format_and_observe
  localparam logic [7:0] IDX_GAIN_CLIP = 8'h1E; // gain_clip_limit
  localparam logic [7:0] IDX_SAT_COUNTS = 8'h20; // saturation_counts
  localparam logic [7:0] IDX_RF_PAD = 8'h22; // rf_pad_value
  localparam logic [7:0] IDX_HI_SAT = 8'h24; // high_saturation_step
  localparam int REG_COUNT = 7; // registers in the bank
  localparam logic [7:0] REG_RESET = 8'h00; // every register clears on reset
  // slot numbers inside the storage array
  localparam logic [2:0] SLOT_CLK = 3'h0;
  localparam logic [2:0] SLOT_PWR = 3'h1;
  localparam logic [2:0] SLOT_FMT = 3'h2;
  localparam logic [2:0] SLOT_CLIP = 3'h3;
  localparam logic [2:0] SLOT_SAT = 3'h4;
  localparam logic [2:0] SLOT_PAD = 3'h5;
  localparam logic [2:0] SLOT_HI = 3'h6;
  // field positions
  localparam int BIT_CLK_SRC = 7; // clock source select
  localparam int BIT_MANUAL = 0; // manual power control
  localparam int BIT_FORMAT = 7; // offset binary select
  localparam int BIT_OBS_LSB = 4; // observation source field low bit
  localparam int BIT_TESTBUS = 3; // test bus into dacs
  localparam int BIT_RFAD = 2; // rf a/d into receive dac
  // observation dac source codes
  typedef enum logic [2:0] {
    OBS_TX_FILTER = 3'b000,
    OBS_DOWN_CONV = 3'b001,
    OBS_CHIP_TIMING = 3'b010,
    OBS_ADC = 3'b011,
    OBS_WINNER = 3'b100,
    OBS_WEIGHTS = 3'b101,
    OBS_TEST_BUS = 3'b110,
    OBS_CORR = 3'b111
  } cta_obs_src_t;
  localparam logic [5:0] SYNC_PULSE = 6'h20; // full scale negative, 6-bit two's complement
  localparam logic [3:0] LAST_WEIGHT = 4'hF; // sixteen weights per sequence
  localparam logic [6:0] PD_ALL_ON = 7'h7F; // every power-down asserted during reset
  // a pair of 6-bit converter samples
  typedef struct packed {
    logic [5:0] i;
    logic [5:0] q;
  } cta_iq_t;
  // converter power-down group, bit order matches the override register bits 7:1
  typedef struct packed {
    logic standby;
    logic transmit_sleep;
    logic receive_sleep;
    logic iq_sleep;
    logic analog_tx_shutdown;
    logic analog_rx_shutdown;
    logic analog_standby;
  } cta_pwr_t;
  // converter clock enables, bit order matches the gating register bits 6:0
  typedef struct packed {
    logic tx_dac;
    logic rx_dac;
    logic i_dac;
    logic q_dac;
    logic rf_adc;
    logic i_adc;
    logic q_adc;
  } cta_clk_en_t;
endpackage

/* File: logic/cta_observe_mux.sv */
// Purpose: selects the internal signal shown on the i/q observation dacs
// Assumes: all sources synchronous to pclk, 6-bit two's complement on the dac
// Notes: weight sequencer free-runs so the sync pulse lands at a fixed period
`timescale 1ns/1ns
module cta_observe_mux (
  input wire logic pclk, // baseband clock
  input wire logic presetn, // async reset, active low
  input wire cta_pkg::cta_obs_src_t src, // selected source
  input wire cta_pkg::cta_iq_t tx_filter, // transmit filter output
  input wire cta_pkg::cta_iq_t down_conv, // down converter output
  input wire cta_pkg::cta_iq_t adc_iq, // i and q a/d samples
  input wire logic [11:0] chip_timing_accumulator, // early/late integrator
  input wire logic [7:0] transform_winner_i, // peak picker winner i
  input wire logic [7:0] transform_winner_q, // peak picker winner q
  input wire logic [127:0] matched_filter_weights, // sixteen 8-bit weights
  input wire logic [5:0] test_bus_in, // test bus pins
  input wire logic test_bus_is_input, // test bus configured as inputs
  input wire logic corr_sel_lowrate, // 1 selects low-rate samples
  input wire cta_pkg::cta_iq_t barker_corr, // barker correlator samples
  input wire cta_pkg::cta_iq_t lowrate, // low-rate samples
  output cta_pkg::cta_iq_t obs // observation dac data
);
  logic [3:0] weight_idx_r; // weight being shown
  logic sync_slot_r; // sync pulse slot between sequences
  logic [5:0] weight_top; // upper bits of current weight
  cta_pkg::cta_iq_t obs_nxt; // next dac value

  // circular weight walk with one sync slot after the last weight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      weight_idx_r <= 4'h0;
      sync_slot_r <= 1'b0;
    end else if (sync_slot_r) begin
      sync_slot_r <= 1'b0;
      weight_idx_r <= 4'h0;
    end else if (weight_idx_r == cta_pkg::LAST_WEIGHT) begin
      sync_slot_r <= 1'b1;
    end else begin
      weight_idx_r <= weight_idx_r + 4'h1;
    end
  end

  assign weight_top = matched_filter_weights[{weight_idx_r, 3'b111} -: 6];

  // source selection
  always_comb begin
    obs_nxt = '0;
    case (src)
      cta_pkg::OBS_TX_FILTER: obs_nxt = tx_filter;
      cta_pkg::OBS_DOWN_CONV: obs_nxt = down_conv;
      cta_pkg::OBS_CHIP_TIMING: begin
        obs_nxt.i = 6'h00;
        obs_nxt.q = chip_timing_accumulator[11:6];
      end
      cta_pkg::OBS_ADC: obs_nxt = adc_iq;
      cta_pkg::OBS_WINNER: begin
        obs_nxt.i = transform_winner_i[7:2];
        obs_nxt.q = transform_winner_q[7:2];
      end
      cta_pkg::OBS_WEIGHTS: begin
        obs_nxt.i = sync_slot_r ? cta_pkg::SYNC_PULSE : weight_top;
        obs_nxt.q = sync_slot_r ? cta_pkg::SYNC_PULSE : weight_top;
      end
      cta_pkg::OBS_TEST_BUS: begin
        obs_nxt.i = test_bus_is_input ? test_bus_in : 6'h00;
        obs_nxt.q = test_bus_is_input ? test_bus_in : 6'h00;
      end
      cta_pkg::OBS_CORR: obs_nxt = corr_sel_lowrate ? lowrate : barker_corr;
      default: obs_nxt = '0;
    endcase
  end

  // dac data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      obs <= '0;
    end else begin
      obs <= obs_nxt;
    end
  end

  chk_sync_gap: assert property (@(posedge pclk) disable iff (!presetn)
    sync_slot_r |=> !sync_slot_r && weight_idx_r == 4'h0)
    else $error("sync slot not followed by weight zero");
endmodule

/* File: logic/cta_regs.sv */
// Purpose: apb register bank for converter clocks, power, format, observation and agc limits
// Assumes: apb master per protocol, paddr is a byte address, no wait states needed
// Notes: read data is captured in the setup cycle so prdata comes from a flop
`timescale 1ns/1ns
// Functional notes
// - clock source bit picks internal or serial pin
// - seven gating bits stop each converter clock
// - manual bit selects register or automatic power-down
// - upper seven bits drive individual power-downs manually
// - format bit selects two's complement or offset
// - codes 000, 001, 011 route filter, downconverter, adcs
// - code 010 shows chip timing on q
// - code 100 shows transform winners
// - code 101 cycles weights with sync pulse
// - codes 110, 111 give test bus, correlator
// - test bus feeds both dacs when enabled
// - rf a/d into receive dac overrides test bus
// - attenuator accumulator clamped between zero and clip
// - unused bits stored, no effect, write zero
// - saturation counts: mid upper, low lower nibble
// - rf pad value added into strength result
// - high step is twice value above count
// - high saturation count in lower nibble
module cta_regs (
  input wire logic pclk, // baseband clock, 25 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, 1 write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  output logic conv_clk_from_serial, // converters clocked from serial data pin
  output cta_pkg::cta_clk_en_t conv_clk_en, // per converter clock enable
  input wire logic transmit_power_enable, // transmit power enable input
  input wire logic receive_power_enable, // receive power enable input
  output cta_pkg::cta_pwr_t conv_power_down, // converter power-down signals
  input wire cta_pkg::cta_iq_t adc_iq_raw, // i/q a/d samples, two's complement
  input wire logic [5:0] adc_rf_raw, // rf a/d sample, two's complement
  output cta_pkg::cta_iq_t adc_iq_fmt, // formatted i/q samples
  output logic [5:0] adc_rf_fmt, // formatted rf sample
  input wire cta_pkg::cta_iq_t tx_filter, // transmit filter output
  input wire cta_pkg::cta_iq_t down_conv, // down converter output
  input wire logic [11:0] chip_timing_accumulator, // early/late integrator
  input wire logic [7:0] transform_winner_i, // peak picker winner i
  input wire logic [7:0] transform_winner_q, // peak picker winner q
  input wire logic [127:0] matched_filter_weights, // sixteen 8-bit weights
  input wire logic [5:0] test_bus_in, // test bus pins
  input wire logic test_bus_is_input, // test bus pins configured as inputs
  input wire logic corr_sel_lowrate, // correlator view select
  input wire cta_pkg::cta_iq_t barker_corr, // barker correlator samples
  input wire cta_pkg::cta_iq_t lowrate, // low-rate samples
  output cta_pkg::cta_iq_t obs_dac, // observation dac data
  input wire logic [5:0] rx_dac_normal, // normal receive dac data
  input wire logic [5:0] tx_dac_normal, // normal transmit dac data
  output logic [5:0] rx_dac_data, // receive dac data
  output logic [5:0] tx_dac_data, // transmit dac data
  input wire logic agc_update, // one-cycle agc accumulator update
  input wire logic signed [7:0] agc_delta, // signed attenuation change
  input wire logic sat_eval, // one-cycle saturation evaluation
  input wire logic [4:0] sat_count, // i and q saturations in window
  input wire logic rf_gain_pad_control, // rf pad inserted
  output logic [6:0] atten_acc, // attenuator accumulator
  output logic mid_step_req, // mid attenuator step due
  output logic low_step_req, // low attenuator step due
  output logic high_step_req, // high attenuator step due
  output logic [4:0] high_step_atten, // high step size
  output logic [7:0] received_strength_value // strength result
);
  logic [7:0] regs_r [cta_pkg::REG_COUNT]; // register storage
  logic [3:0] slot_dec; // decoded slot, bit 3 flags a miss
  logic [2:0] acc_slot; // decoded slot of current access
  logic acc_hit; // address maps to a register
  logic wr_en; // write takes effect this edge
  logic [7:0] rd_byte; // selected read byte
  logic signed [9:0] acc_sum; // unclamped accumulator sum
  logic [6:0] acc_nxt; // clamped accumulator
  logic [6:0] clip; // gain clip value
  logic [4:0] hi_step; // doubled high step

  // map a byte address to a storage slot, bit 3 flags a miss
  function automatic logic [3:0] addr_to_slot(input logic [7:0] addr);
    logic [3:0] res;
    res = 4'h8;
    if (addr[1:0] == 2'b00) begin
      case (addr[7:2])
        cta_pkg::IDX_CLK_GATING[5:0]: res = {1'b0, cta_pkg::SLOT_CLK};
        cta_pkg::IDX_PWR_OVERRIDE[5:0]: res = {1'b0, cta_pkg::SLOT_PWR};
        cta_pkg::IDX_FMT_OBSERVE[5:0]: res = {1'b0, cta_pkg::SLOT_FMT};
        cta_pkg::IDX_GAIN_CLIP[5:0]: res = {1'b0, cta_pkg::SLOT_CLIP};
        cta_pkg::IDX_SAT_COUNTS[5:0]: res = {1'b0, cta_pkg::SLOT_SAT};
        cta_pkg::IDX_RF_PAD[5:0]: res = {1'b0, cta_pkg::SLOT_PAD};
        cta_pkg::IDX_HI_SAT[5:0]: res = {1'b0, cta_pkg::SLOT_HI};
        default: res = 4'h8;
      endcase
    end
    return res;
  endfunction

  // access decode, used by write, read and error paths
  assign slot_dec = addr_to_slot(paddr);
  assign acc_slot = slot_dec[2:0];
  assign acc_hit = !slot_dec[3];
  assign pready = psel & penable; // zero wait states
  assign pslverr = psel & penable & !acc_hit; // unmapped address answers with error
  assign wr_en = psel & penable & pwrite & acc_hit;
  assign rd_byte = acc_hit ? regs_r[acc_slot] : 8'h00;

  // register storage, every bit kept including unused ones
  generate
    for (genvar g = 0; g < cta_pkg::REG_COUNT; g++) begin : g_reg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          regs_r[g] <= cta_pkg::REG_RESET;
        end else if (wr_en && acc_slot == 3'(g)) begin
          regs_r[g] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // read data captured in setup cycle, upper bits read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // clock source and gating, a 1 stops the clock
  assign conv_clk_from_serial = regs_r[cta_pkg::SLOT_CLK][cta_pkg::BIT_CLK_SRC];
  assign conv_clk_en = ~regs_r[cta_pkg::SLOT_CLK][6:0];

  // power-down: manual from register bits 7:1, else from the enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_power_down <= cta_pkg::PD_ALL_ON;
    end else if (regs_r[cta_pkg::SLOT_PWR][cta_pkg::BIT_MANUAL]) begin
      conv_power_down <= regs_r[cta_pkg::SLOT_PWR][7:1];
    end else begin
      conv_power_down.standby <= 1'b0;
      conv_power_down.transmit_sleep <= !transmit_power_enable;
      conv_power_down.receive_sleep <= !receive_power_enable;
      conv_power_down.iq_sleep <= !(transmit_power_enable | receive_power_enable);
      conv_power_down.analog_tx_shutdown <= !transmit_power_enable;
      conv_power_down.analog_rx_shutdown <= !receive_power_enable;
      conv_power_down.analog_standby <= !(transmit_power_enable | receive_power_enable);
    end
  end

  // converter number format, offset binary flips the sign bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_iq_fmt <= '0;
      adc_rf_fmt <= 6'h00;
    end else begin
      adc_iq_fmt.i <= adc_iq_raw.i ^ {regs_r[cta_pkg::SLOT_FMT][cta_pkg::BIT_FORMAT], 5'h00};
      adc_iq_fmt.q <= adc_iq_raw.q ^ {regs_r[cta_pkg::SLOT_FMT][cta_pkg::BIT_FORMAT], 5'h00};
      adc_rf_fmt <= adc_rf_raw ^ {regs_r[cta_pkg::SLOT_FMT][cta_pkg::BIT_FORMAT], 5'h00};
    end
  end

  // observation dac selector
  cta_observe_mux u_obs (
    .pclk(pclk),
    .presetn(presetn),
    .src(cta_pkg::cta_obs_src_t'(regs_r[cta_pkg::SLOT_FMT][6:4])),
    .tx_filter(tx_filter),
    .down_conv(down_conv),
    .adc_iq(adc_iq_raw),
    .chip_timing_accumulator(chip_timing_accumulator),
    .transform_winner_i(transform_winner_i),
    .transform_winner_q(transform_winner_q),
    .matched_filter_weights(matched_filter_weights),
    .test_bus_in(test_bus_in),
    .test_bus_is_input(test_bus_is_input),
    .corr_sel_lowrate(corr_sel_lowrate),
    .barker_corr(barker_corr),
    .lowrate(lowrate),
    .obs(obs_dac)
  );

  // receive and transmit dac routing, rf a/d has priority
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_dac_data <= 6'h00;
      tx_dac_data <= 6'h00;
    end else begin
      if (regs_r[cta_pkg::SLOT_FMT][cta_pkg::BIT_RFAD]) begin
        rx_dac_data <= adc_rf_raw;
      end else if (regs_r[cta_pkg::SLOT_FMT][cta_pkg::BIT_TESTBUS]) begin
        rx_dac_data <= test_bus_in;
      end else begin
        rx_dac_data <= rx_dac_normal;
      end
      if (regs_r[cta_pkg::SLOT_FMT][cta_pkg::BIT_TESTBUS] && !regs_r[cta_pkg::SLOT_FMT][cta_pkg::BIT_RFAD]) begin
        tx_dac_data <= test_bus_in;
      end else begin
        tx_dac_data <= tx_dac_normal;
      end
    end
  end

  // agc limits; bit 7 of clip and pad bits 7:6 are ignored
  assign clip = regs_r[cta_pkg::SLOT_CLIP][6:0];
  assign hi_step = {regs_r[cta_pkg::SLOT_HI][7:4], 1'b0};

  // accumulator step, high saturation step subtracts on evaluation
  always_comb begin
    acc_sum = 10'(signed'({3'b000, atten_acc}));
    if (agc_update) begin
      acc_sum = acc_sum + 10'(agc_delta);
    end
    if (sat_eval && sat_count > {1'b0, regs_r[cta_pkg::SLOT_HI][3:0]}) begin
      acc_sum = acc_sum - 10'(signed'({5'h00, hi_step}));
    end
    if (acc_sum < 10'sd0) begin
      acc_nxt = 7'h00;
    end else if (acc_sum > 10'(signed'({3'b000, clip}))) begin
      acc_nxt = clip;
    end else begin
      acc_nxt = acc_sum[6:0];
    end
  end

  // accumulator register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      atten_acc <= 7'h00;
    end else if (agc_update || sat_eval) begin
      atten_acc <= acc_nxt;
    end
  end

  // saturation step requests, refreshed on each evaluation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mid_step_req <= 1'b0;
      low_step_req <= 1'b0;
      high_step_req <= 1'b0;
      high_step_atten <= 5'h00;
    end else if (sat_eval) begin
      mid_step_req <= sat_count > {1'b0, regs_r[cta_pkg::SLOT_SAT][7:4]};
      low_step_req <= sat_count > {1'b0, regs_r[cta_pkg::SLOT_SAT][3:0]};
      high_step_req <= sat_count > {1'b0, regs_r[cta_pkg::SLOT_HI][3:0]};
      high_step_atten <= hi_step;
    end
  end

  // strength result adds the rf pad while the pad is inserted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      received_strength_value <= 8'h00;
    end else begin
      received_strength_value <= {1'b0, atten_acc} +
        (rf_gain_pad_control ? {2'b00, regs_r[cta_pkg::SLOT_PAD][5:0]} : 8'h00);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_write_readback: assert property (wr_en |=> regs_r[$past(acc_slot)] == $past(pwdata[7:0]))
    else $error("written byte not stored");
  chk_clk_gating: assert property (wr_en && acc_slot == cta_pkg::SLOT_CLK |=>
    conv_clk_en == ~$past(pwdata[6:0]))
    else $error("clock enable does not follow gating write");
  chk_clk_source: assert property (wr_en && acc_slot == cta_pkg::SLOT_CLK |=>
    conv_clk_from_serial == $past(pwdata[7]))
    else $error("clock source select wrong");
  chk_pd_manual: assert property (regs_r[cta_pkg::SLOT_PWR][0] |=>
    conv_power_down == $past(regs_r[cta_pkg::SLOT_PWR][7:1]))
    else $error("manual power-down mismatch");
  chk_pd_auto: assert property (!regs_r[cta_pkg::SLOT_PWR][0] |=>
    conv_power_down.transmit_sleep == !$past(transmit_power_enable) && !conv_power_down.standby)
    else $error("automatic power-down mismatch");
  chk_format_flip: assert property (1'b1 |=>
    adc_rf_fmt[5] == ($past(adc_rf_raw[5]) ^ $past(regs_r[cta_pkg::SLOT_FMT][7])))
    else $error("rf format sign bit wrong");
  chk_obs_timing: assert property (regs_r[cta_pkg::SLOT_FMT][6:4] == 3'b010 |=>
    obs_dac.i == 6'h00 && obs_dac.q == $past(chip_timing_accumulator[11:6]))
    else $error("chip timing view wrong");
  chk_rfad_route: assert property (regs_r[cta_pkg::SLOT_FMT][2] |=>
    rx_dac_data == $past(adc_rf_raw))
    else $error("rf a/d not on receive dac");
  chk_testbus_tx: assert property (regs_r[cta_pkg::SLOT_FMT][3:2] == 2'b10 |=>
    tx_dac_data == $past(test_bus_in) && rx_dac_data == $past(test_bus_in))
    else $error("test bus not on dacs");
  chk_acc_clip: assert property (agc_update |=> atten_acc <= $past(clip))
    else $error("accumulator above gain clip");
  chk_hi_step: assert property (sat_eval && sat_count > {1'b0, regs_r[cta_pkg::SLOT_HI][3:0]} |=>
    high_step_req && high_step_atten == {$past(regs_r[cta_pkg::SLOT_HI][7:4]), 1'b0})
    else $error("high step size or request wrong");
  chk_pad_sum: assert property (!rf_gain_pad_control |=>
    received_strength_value == {1'b0, $past(atten_acc)})
    else $error("strength value includes pad while removed");
  chk_pad_added: assert property (rf_gain_pad_control |=>
    received_strength_value == {1'b0, $past(atten_acc)} + {2'b00, $past(regs_r[cta_pkg::SLOT_PAD][5:0])})
    else $error("strength value misses pad while inserted");
  chk_mid_low_step: assert property (sat_eval |=>
    mid_step_req == ($past(sat_count) > {1'b0, $past(regs_r[cta_pkg::SLOT_SAT][7:4])}) &&
    low_step_req == ($past(sat_count) > {1'b0, $past(regs_r[cta_pkg::SLOT_SAT][3:0])}))
    else $error("mid or low step request wrong");
  chk_iq_format: assert property (1'b1 |=>
    adc_iq_fmt.i[5] == ($past(adc_iq_raw.i[5]) ^ $past(regs_r[cta_pkg::SLOT_FMT][7])))
    else $error("i format sign bit wrong");
  chk_obs_winner: assert property (regs_r[cta_pkg::SLOT_FMT][6:4] == 3'b100 |=>
    obs_dac.i == $past(transform_winner_i[7:2]) && obs_dac.q == $past(transform_winner_q[7:2]))
    else $error("winner view wrong");
  chk_read_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  cov_manual_pd: cover property (regs_r[cta_pkg::SLOT_PWR][0] && regs_r[cta_pkg::SLOT_PWR][7]);
  cov_weights_view: cover property (regs_r[cta_pkg::SLOT_FMT][6:4] == 3'b101 ##1 obs_dac.i == cta_pkg::SYNC_PULSE);
  cov_acc_clipped: cover property (agc_update ##1 atten_acc == clip && clip != 7'h00);
  cov_unmapped: cover property (pslverr);
endmodule

/* File: sim/tb.sv */
// Purpose: self-checking bench for the converter test and agc limit register bank
// Assumes: apb answers without wait states, outputs settle within two edges of a write
// Notes: each scenario is its own task; ports are connected by matching names
`timescale 1ns/1ns
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, conv_clk_from_serial; // apb and clock select
  logic transmit_power_enable, receive_power_enable, test_bus_is_input, corr_sel_lowrate; // side inputs
  logic agc_update, sat_eval, rf_gain_pad_control, mid_step_req, low_step_req, high_step_req, rerr; // agc
  logic [7:0] paddr, transform_winner_i, transform_winner_q, received_strength_value; // bytes
  logic [31:0] pwdata, prdata, rdat; // apb data
  cta_pkg::cta_clk_en_t conv_clk_en; // clock enables
  cta_pkg::cta_pwr_t conv_power_down; // power-downs
  cta_pkg::cta_iq_t adc_iq_raw, adc_iq_fmt, tx_filter, down_conv, barker_corr, lowrate, obs_dac; // i/q pairs
  logic [5:0] adc_rf_raw, adc_rf_fmt, test_bus_in, rx_dac_normal, tx_dac_normal, rx_dac_data, tx_dac_data;
  logic [11:0] chip_timing_accumulator; // timing integrator
  logic [127:0] matched_filter_weights; // weight bank
  logic signed [7:0] agc_delta; // accumulator change
  logic [4:0] sat_count, high_step_atten; // saturation figures
  logic [6:0] atten_acc; // accumulator
  int error_cnt, comparisons; // tallies
  cta_regs DUT (.*);
  // free running 25 MHz clock
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  // compare one result and tally it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // let register effects and flopped outputs land
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask
  // one agc update or saturation evaluation pulse
  task automatic pulse(input logic s, input logic signed [7:0] d, input logic [4:0] n);
    @(posedge pclk);
    {agc_update, sat_eval, agc_delta, sat_count} <= {!s, s, d, n};
    @(posedge pclk);
    {agc_update, sat_eval} <= 2'b00;
    #1;
  endtask
  // reset values, full readback, unmapped access
  task automatic t_regs();
    for (int i = 0; i < 7; i++) begin
      apb(8'h60 + 8'(i * 8), 1'b0, 32'h0);
      chk(rdat, 32'h0);
      apb(8'h60 + 8'(i * 8), 1'b1, {24'hABCDEF, 8'hC3 ^ 8'(i)});
      apb(8'h60 + 8'(i * 8), 1'b0, 32'h0);
      chk(rdat, {24'h0, 8'hC3 ^ 8'(i)});
    end
    apb(8'h64, 1'b0, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    $display("register test done");
  endtask
  // clock select, gating, power override, format and dac routing
  task automatic t_conv();
    apb(8'h60, 1'b1, 32'hA5);
    settle();
    chk({31'h0, conv_clk_from_serial}, 32'h1);
    chk({25'h0, conv_clk_en}, 32'h5A);
    apb(8'h68, 1'b1, 32'h0);
    settle();
    chk({25'h0, conv_power_down}, 32'h12);
    apb(8'h68, 1'b1, 32'hB5);
    settle();
    chk({25'h0, conv_power_down}, 32'h5A);
    apb(8'h70, 1'b1, 32'h80);
    settle();
    chk({12'h0, adc_iq_fmt, 2'b00, adc_rf_fmt}, 32'h7E1_25);
    apb(8'h70, 1'b1, 32'h08);
    settle();
    chk({20'h0, rx_dac_data, tx_dac_data}, 32'h555);
    apb(8'h70, 1'b1, 32'h0C);
    settle();
    chk({26'h0, rx_dac_data}, 32'h05);
    $display("converter test done");
  endtask
  // observation source codes
  task automatic t_obs();
    logic [2:0] code [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
    logic [11:0] exp [7] = '{12'h111, 12'h222, 12'h02A, 12'hFC1, 12'hFD0, 12'h555, 12'h333};
    for (int i = 0; i < 7; i++) begin
      apb(8'h70, 1'b1, {25'h0, code[i], 4'h0});
      settle();
      chk({20'h0, obs_dac}, {20'h0, exp[i]});
    end
    corr_sel_lowrate <= 1'b1;
    settle();
    chk({20'h0, obs_dac}, 32'h444);
    $display("observation test done");
  endtask
  // weight view: find the sync slot, then sixteen weights in order and the next sync
  task automatic t_weights();
    int n;
    apb(8'h70, 1'b1, 32'h50);
    settle();
    n = 0;
    while (obs_dac !== 12'h820 && n < 40) begin
      @(posedge pclk);
      #1;
      n++;
    end
    for (int k = 0; k < 17; k++) begin
      @(posedge pclk);
      #1;
      chk({20'h0, obs_dac}, (k == 16) ? 32'h820 : {20'h0, 6'(k), 6'(k)});
    end
    $display("weight view test done");
  endtask
  // accumulator clamp, saturation steps and strength value
  task automatic t_agc();
    apb(8'h78, 1'b1, 32'h0C);
    pulse(1'b0, 8'sd10, 5'h0);
    chk({25'h0, atten_acc}, 32'h0A);
    pulse(1'b0, 8'sd5, 5'h0);
    chk({25'h0, atten_acc}, 32'h0C);
    pulse(1'b0, -8'sd100, 5'h0);
    chk({25'h0, atten_acc}, 32'h00);
    pulse(1'b0, 8'sd12, 5'h0);
    apb(8'h90, 1'b1, 32'h34);
    apb(8'h80, 1'b1, 32'h21);
    pulse(1'b1, 8'sd0, 5'd5);
    chk({19'h0, high_step_req, high_step_atten, atten_acc}, {19'h0, 1'b1, 5'h06, 7'h06});
    pulse(1'b1, 8'sd0, 5'd4);
    chk({29'h0, high_step_req, mid_step_req, low_step_req}, 32'h3);
    pulse(1'b1, 8'sd0, 5'd2);
    chk({30'h0, mid_step_req, low_step_req}, 32'h1);
    apb(8'h88, 1'b1, 32'h1E);
    rf_gain_pad_control <= 1'b1;
    settle();
    chk({24'h0, received_strength_value}, 32'h24);
    $display("agc test done");
  endtask
  // verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // cuts a hang short
  initial begin
    #2000000;
    error_cnt++;
    final_report();
  end
  // time zero values, reset, then the scenarios
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, agc_update, sat_eval, agc_delta, sat_count} = '0;
    {transmit_power_enable, receive_power_enable, test_bus_is_input, corr_sel_lowrate} = 4'b1010;
    {rf_gain_pad_control, adc_iq_raw, adc_rf_raw, test_bus_in} = {1'b0, 12'hFC1, 6'h05, 6'h15};
    {tx_filter, down_conv, barker_corr, lowrate} = {12'h111, 12'h222, 12'h333, 12'h444};
    {chip_timing_accumulator, transform_winner_i, transform_winner_q} = {12'hABC, 8'hFC, 8'h40};
    {matched_filter_weights, rx_dac_normal, tx_dac_normal} = {128'h3C383430_2C282420_1C181410_0C080400, 6'h11, 6'h22};
    error_cnt = 0;
    comparisons = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_conv();
    t_obs();
    t_weights();
    t_agc();
    final_report();
  end
endmodule
